// ===== rtl/cps_core_regs.sv
// module: programmer-visible core state, program counter, flag banks and return stack

// Notes on behaviour
// - 8-bit accumulator, also read and written as data-space location FFh.
// - two pointer registers mapped at data-space 80h and 81h.
// - two short-direct registers mapped at data-space 82h and 83h.
// - program counter is 12 bits, addressing 4096 program bytes.
// - program counter advances by one after each fetch.
// - relative branch adds signed offset to program counter and reloads it.
// - pc loads target, vector, reset vector, or popped stack value.
// - three carry/zero pairs: main, interrupt, non-maskable contexts.
// - interrupt entry switches flag pair; return-from-interrupt restores previous pair.
// - pairs keep values across switches; only the active pair is touched.
// - carry from arithmetic carry/borrow, bit test bit, and rotate-left feed.
// - zero set when last arithmetic or logic result is zero.
// - after reset the non-maskable context and its flags are active.
// - six-level 12-bit return stack, outside data space, no pointer visible.
// - push shifts levels deeper, pc enters level one, sixth is lost.
// - pop moves level one into pc, others shift toward level one.
// - beyond six nested pushes depth stays six, oldest address lost silently.
// - return on empty stack leaves pc and stack unchanged; execution simply continues.
// - machine cycle is the clock divided by thirteen.
// - instructions take two, four or five machine cycles.
module cps_core_regs (
	input  wire logic                  ref_clk,
	input  wire logic                  rstn,
	// instruction command port
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire cps_pkg::cps_cmd_s     cmd,
	// data-space access
	input  wire cps_pkg::cps_ds_req_s  ds_req,
	output logic [7:0]                 ds_rdata,
	output logic                       ds_hit,
	// visible state
	output logic [cps_pkg::PC_W-1:0]   pc,
	output logic [7:0]                 accumulator,
	output logic                       carry_active,
	output logic                       zero_active,
	output cps_pkg::cps_ctx_e          ctx,
	output logic [cps_pkg::DEPTH_W-1:0] stack_depth,
	output logic                       mc_tick,
	output logic                       busy
);
	import cps_pkg::*;

	// ------------------------------------------------------------------
	// reset synchroniser
	// ------------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_n;

	// release only through two flops so every register leaves reset together
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// machine cycle divider
	// ------------------------------------------------------------------
	logic [3:0] div_reg;
	logic       tick_reg;

	// one-cycle enable every thirteen clocks
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			div_reg  <= 4'h0;
			tick_reg <= 1'b0;
		end else begin
			if (div_reg == MC_DIV - 4'h1) begin
				div_reg  <= 4'h0;
				tick_reg <= 1'b1;
			end else begin
				div_reg  <= div_reg + 4'h1;
				tick_reg <= 1'b0;
			end
		end
	end

	assign mc_tick = tick_reg;

	// ------------------------------------------------------------------
	// instruction length sequencing
	// ------------------------------------------------------------------
	logic [2:0] cyc_left_reg;
	logic       accept;
	logic [2:0] cyc_len;

	// illegal lengths are rounded to the shortest legal one
	always_comb begin
		unique case (cmd.cycles)
			CYC_MID: cyc_len = CYC_MID;
			CYC_MAX: cyc_len = CYC_MAX;
			default: cyc_len = CYC_MIN;
		endcase
	end

	assign busy      = (cyc_left_reg != 3'h0);
	assign cmd_ready = tick_reg && !busy;
	assign accept    = cmd_valid && cmd_ready;

	// the command acts on its first machine cycle, the rest are idle holds
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cyc_left_reg <= 3'h0;
		end else if (accept) begin
			cyc_left_reg <= cyc_len - 3'h1;
		end else if (tick_reg && busy) begin
			cyc_left_reg <= cyc_left_reg - 3'h1;
		end
	end

	// ------------------------------------------------------------------
	// decoded command events
	// ------------------------------------------------------------------
	logic do_push;
	logic do_pop;
	logic pop_ok;
	logic do_alu;

	assign do_push = accept && (cmd.op == CPS_OP_CALL || cmd.op == CPS_OP_IRQ
		|| cmd.op == CPS_OP_NMI);
	assign do_pop  = accept && (cmd.op == CPS_OP_RET || cmd.op == CPS_OP_RETURN_FROM_INTERRUPT);
	assign pop_ok  = do_pop && (stack_depth != 3'h0);
	assign do_alu  = accept && (cmd.op == CPS_OP_ARITH || cmd.op == CPS_OP_LOGIC
		|| cmd.op == CPS_OP_BITTEST || cmd.op == CPS_OP_ROTL);

	// ------------------------------------------------------------------
	// return stack
	// ------------------------------------------------------------------
	logic [PC_W-1:0]    stack_mem [STACK_DEPTH];
	logic [DEPTH_W-1:0] depth_reg;

	// each level takes its neighbour; the stack holds addresses only
	generate
		for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_level
			always_ff @(posedge ref_clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					stack_mem[i] <= STACK_RESET;
				end else if (do_push) begin
					// clamped index keeps the unused neighbour select in range
					stack_mem[i] <= (i == 0) ? pc
						: stack_mem[(i == 0) ? 0 : i - 1];
				end else if (pop_ok) begin
					stack_mem[i] <= (i == STACK_DEPTH - 1) ? STACK_RESET
						: stack_mem[(i == STACK_DEPTH - 1) ? i : i + 1];
				end
			end
		end
	endgenerate

	// depth saturates both ways, no overflow or underflow flag
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			depth_reg <= 3'h0;
		end else if (do_push) begin
			if (depth_reg != DEPTH_W'(STACK_DEPTH)) begin
				depth_reg <= depth_reg + 3'h1;
			end
		end else if (pop_ok) begin
			depth_reg <= depth_reg - 3'h1;
		end
	end

	assign stack_depth = depth_reg;

	// ------------------------------------------------------------------
	// program counter
	// ------------------------------------------------------------------
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic [PC_W-1:0] branch_sum;

	// offset is sign extended before the add; wraps within 4 kbyte
	assign branch_sum = pc_reg + {{(PC_W-8){cmd.offset[7]}}, cmd.offset};

	always_comb begin
		pc_next = pc_reg;
		if (accept) begin
			unique case (cmd.op)
				CPS_OP_FETCH:  pc_next = pc_reg + 12'h001;
				CPS_OP_JUMP,
				CPS_OP_CALL:   pc_next = cmd.target;
				CPS_OP_BRANCH: pc_next = branch_sum;
				CPS_OP_IRQ,
				CPS_OP_NMI:    pc_next = cmd.target;
				CPS_OP_RET,
				CPS_OP_RETURN_FROM_INTERRUPT: begin
					if (pop_ok) begin
						pc_next = stack_mem[0];
					end
				end
				default:       pc_next = pc_reg;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pc_reg <= RESET_VEC;
		end else begin
			pc_reg <= pc_next;
		end
	end

	assign pc = pc_reg;

	// ------------------------------------------------------------------
	// context tracking
	// ------------------------------------------------------------------
	cps_ctx_e ctx_reg;
	cps_ctx_e ctx_hist_reg [2];

	// two saved contexts cover main under interrupt under non-maskable
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctx_reg         <= CPS_CTX_NMI;
			ctx_hist_reg[0] <= CPS_CTX_MAIN;
			ctx_hist_reg[1] <= CPS_CTX_MAIN;
		end else if (accept && cmd.op == CPS_OP_IRQ) begin
			ctx_reg         <= CPS_CTX_IRQ;
			ctx_hist_reg[0] <= ctx_reg;
			ctx_hist_reg[1] <= ctx_hist_reg[0];
		end else if (accept && cmd.op == CPS_OP_NMI) begin
			ctx_reg         <= CPS_CTX_NMI;
			ctx_hist_reg[0] <= ctx_reg;
			ctx_hist_reg[1] <= ctx_hist_reg[0];
		end else if (accept && cmd.op == CPS_OP_RETURN_FROM_INTERRUPT) begin
			ctx_reg         <= ctx_hist_reg[0];
			ctx_hist_reg[0] <= ctx_hist_reg[1];
			ctx_hist_reg[1] <= CPS_CTX_MAIN;
		end
	end

	assign ctx = ctx_reg;

	// ------------------------------------------------------------------
	// flag banks
	// ------------------------------------------------------------------
	logic [7:0] acc_reg;
	logic carry_main_ctx;
	logic zero_main_ctx;
	logic carry_irq_ctx;
	logic zero_irq_ctx;
	logic carry_nonmask_ctx;
	logic zero_nonmask_ctx;
	logic carry_new;
	logic zero_new;
	logic carry_upd;
	logic zero_upd;

	// pick which flags change and to what
	always_comb begin
		zero_new  = (cmd.result == 8'h00);
		zero_upd  = do_alu && (cmd.op == CPS_OP_ARITH || cmd.op == CPS_OP_LOGIC);
		carry_upd = do_alu && (cmd.op != CPS_OP_LOGIC);
		unique case (cmd.op)
			CPS_OP_ARITH:   carry_new = cmd.carry_out;
			CPS_OP_BITTEST: carry_new = cmd.bit_val;
			CPS_OP_ROTL:    carry_new = acc_reg[7];
			default:        carry_new = carry_active;
		endcase
	end

	// only the bank of the running context moves; others hold untouched
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			carry_main_ctx    <= 1'b0;
			zero_main_ctx     <= 1'b0;
			carry_irq_ctx     <= 1'b0;
			zero_irq_ctx      <= 1'b0;
			carry_nonmask_ctx <= 1'b0;
			zero_nonmask_ctx  <= 1'b0;
		end else begin
			if (carry_upd && ctx_reg == CPS_CTX_MAIN) carry_main_ctx <= carry_new;
			if (zero_upd && ctx_reg == CPS_CTX_MAIN)  zero_main_ctx  <= zero_new;
			if (carry_upd && ctx_reg == CPS_CTX_IRQ)  carry_irq_ctx  <= carry_new;
			if (zero_upd && ctx_reg == CPS_CTX_IRQ)   zero_irq_ctx   <= zero_new;
			if (carry_upd && ctx_reg == CPS_CTX_NMI)  carry_nonmask_ctx <= carry_new;
			if (zero_upd && ctx_reg == CPS_CTX_NMI)   zero_nonmask_ctx  <= zero_new;
		end
	end

	// the visible pair follows the running context
	always_comb begin
		unique case (ctx_reg)
			CPS_CTX_MAIN: begin
				carry_active = carry_main_ctx;
				zero_active  = zero_main_ctx;
			end
			CPS_CTX_IRQ: begin
				carry_active = carry_irq_ctx;
				zero_active  = zero_irq_ctx;
			end
			default: begin
				carry_active = carry_nonmask_ctx;
				zero_active  = zero_nonmask_ctx;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// data-space mapped registers
	// ------------------------------------------------------------------
	logic [7:0] pointer_reg_first;
	logic [7:0] pointer_reg_second;
	logic [7:0] short_direct_first;
	logic [7:0] short_direct_second;

	// a data-space write beats an alu result landing in the same cycle
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			acc_reg <= DATA_RESET;
		end else if (ds_req.wr && ds_req.addr == ADDR_ACCUMULATOR) begin
			acc_reg <= ds_req.wdata;
		end else if (accept && cmd.op == CPS_OP_ROTL) begin
			acc_reg <= {acc_reg[6:0], carry_active};
		end else if (accept && (cmd.op == CPS_OP_ARITH || cmd.op == CPS_OP_LOGIC)) begin
			acc_reg <= cmd.result;
		end
	end

	// pointer and short-direct registers behave as plain ram cells
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pointer_reg_first   <= DATA_RESET;
			pointer_reg_second  <= DATA_RESET;
			short_direct_first  <= DATA_RESET;
			short_direct_second <= DATA_RESET;
		end else if (ds_req.wr) begin
			if (ds_req.addr == ADDR_POINTER_FIRST)  pointer_reg_first   <= ds_req.wdata;
			if (ds_req.addr == ADDR_POINTER_SECOND) pointer_reg_second  <= ds_req.wdata;
			if (ds_req.addr == ADDR_SHORT_FIRST)    short_direct_first  <= ds_req.wdata;
			if (ds_req.addr == ADDR_SHORT_SECOND)   short_direct_second <= ds_req.wdata;
		end
	end

	// registered read; unmapped addresses answer zero with hit low
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ds_rdata <= DATA_RESET;
			ds_hit   <= 1'b0;
		end else if (ds_req.rd) begin
			ds_hit <= 1'b1;
			unique case (ds_req.addr)
				ADDR_POINTER_FIRST:  ds_rdata <= pointer_reg_first;
				ADDR_POINTER_SECOND: ds_rdata <= pointer_reg_second;
				ADDR_SHORT_FIRST:    ds_rdata <= short_direct_first;
				ADDR_SHORT_SECOND:   ds_rdata <= short_direct_second;
				ADDR_ACCUMULATOR:    ds_rdata <= acc_reg;
				default: begin
					ds_rdata <= DATA_RESET;
					ds_hit   <= 1'b0;
				end
			endcase
		end else begin
			ds_hit <= 1'b0;
		end
	end

	assign accumulator = acc_reg;

endmodule // cps_core_regs

// ===== rtl/cps_pkg.sv
// package: constants, enums and carriers for the core register and stack block
package cps_pkg;

	// ------------------------------------------------------------------
	// widths and depths
	// ------------------------------------------------------------------
	localparam int unsigned PC_W        = 12;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned STACK_DEPTH = 6;
	localparam int unsigned DEPTH_W     = 3;

	// ------------------------------------------------------------------
	// data-space offsets of the mapped registers
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_POINTER_FIRST  = 8'h80;
	localparam logic [7:0] ADDR_POINTER_SECOND = 8'h81;
	localparam logic [7:0] ADDR_SHORT_FIRST    = 8'h82;
	localparam logic [7:0] ADDR_SHORT_SECOND   = 8'h83;
	localparam logic [7:0] ADDR_ACCUMULATOR    = 8'hff;

	// ------------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------------
	localparam logic [7:0]      DATA_RESET  = 8'h00;
	localparam logic [PC_W-1:0] RESET_VEC   = 12'hffe;
	localparam logic [PC_W-1:0] STACK_RESET = 12'h000;

	// ------------------------------------------------------------------
	// machine cycle timing
	// ------------------------------------------------------------------
	localparam logic [3:0] MC_DIV      = 4'hd;
	localparam logic [2:0] CYC_MIN     = 3'h2;
	localparam logic [2:0] CYC_MID     = 3'h4;
	localparam logic [2:0] CYC_MAX     = 3'h5;

	// ------------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		CPS_OP_FETCH,
		CPS_OP_JUMP,
		CPS_OP_CALL,
		CPS_OP_BRANCH,
		CPS_OP_IRQ,
		CPS_OP_NMI,
		CPS_OP_RET,
		CPS_OP_RETURN_FROM_INTERRUPT,
		CPS_OP_ARITH,
		CPS_OP_LOGIC,
		CPS_OP_BITTEST,
		CPS_OP_ROTL
	} cps_op_e;

	typedef enum logic [1:0] {
		CPS_CTX_MAIN,
		CPS_CTX_IRQ,
		CPS_CTX_NMI
	} cps_ctx_e;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		cps_op_e         op;
		logic [2:0]      cycles;
		logic [PC_W-1:0] target;
		logic [7:0]      offset;
		logic [7:0]      result;
		logic            carry_out;
		logic            bit_val;
	} cps_cmd_s;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cps_ds_req_s;

endpackage : cps_pkg

// ===== test/cps_core_regs_sva.sv
// checker: port-level timing and state assertions for the core register block
module cps_core_regs_sva (
	input wire logic                    ref_clk,
	input wire logic                    rstn,
	input wire logic                    cmd_valid,
	input wire logic                    cmd_ready,
	input wire cps_pkg::cps_cmd_s       cmd,
	input wire cps_pkg::cps_ds_req_s    ds_req,
	input wire logic [7:0]              ds_rdata,
	input wire logic                    ds_hit,
	input wire logic [cps_pkg::PC_W-1:0] pc,
	input wire logic [7:0]              accumulator,
	input wire logic                    carry_active,
	input wire logic                    zero_active,
	input wire cps_pkg::cps_ctx_e       ctx,
	input wire logic [cps_pkg::DEPTH_W-1:0] stack_depth,
	input wire logic                    mc_tick,
	input wire logic                    busy
);
	timeunit 1ns;
	timeprecision 1ns;
	import cps_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	wire take = cmd_valid & cmd_ready;
	wire push_op = cmd.op inside {CPS_OP_CALL, CPS_OP_IRQ, CPS_OP_NMI};
	wire pop_op = cmd.op inside {CPS_OP_RET, CPS_OP_RETURN_FROM_INTERRUPT};
	wire mapped = ds_req.addr inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
	logic [6:0] left_reg;
	logic [6:0] left_next;

	// clocks left until the next command may be taken; counts other than four and five fall back to two
	always_comb begin
		left_next = (left_reg != 7'h0) ? left_reg - 7'h1 : 7'h0;
		if (take)
			left_next = (cmd.cycles inside {3'h4, 3'h5}) ? 7'(13 * cmd.cycles - 1) : 7'h19;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			left_reg <= 7'h0;
		else
			left_reg <= left_next;
	end

	a_ready_gate: assert property (
		cmd_ready |-> mc_tick && !busy && left_reg == 7'h0) else $error("command taken early");
	a_ready_due: assert property (
		left_reg == 7'h1 |=> cmd_ready) else $error("command port not ready on time");
	a_tick_period: assert property (
		mc_tick |=> !mc_tick [*8] ##1 !mc_tick [*4] ##1 mc_tick) else $error("tick period wrong");
	a_pc_fetch: assert property (
		take && cmd.op == CPS_OP_FETCH |=> pc == $past(pc) + 12'h001) else $error("fetch pc wrong");
	a_pc_load: assert property (
		take && (push_op || cmd.op == CPS_OP_JUMP) |=> pc == $past(cmd.target))
		else $error("pc not loaded with target");
	a_pc_branch: assert property (
		take && cmd.op == CPS_OP_BRANCH
		|=> pc == $past(pc) + {{4{$past(cmd.offset[7])}}, $past(cmd.offset)})
		else $error("branch sum wrong");
	a_push_depth: assert property (
		take && push_op |=> stack_depth ==
		(($past(stack_depth) == 3'h6) ? 3'h6 : $past(stack_depth) + 3'h1))
		else $error("push depth wrong");
	a_pop_depth: assert property (
		take && pop_op && stack_depth != 3'h0 |=> stack_depth == $past(stack_depth) - 3'h1)
		else $error("pop depth wrong");
	a_pop_empty: assert property (
		take && pop_op && stack_depth == 3'h0 |=> pc == $past(pc) && stack_depth == 3'h0)
		else $error("empty pop changed state");
	a_ctx_entry: assert property (
		take && cmd.op inside {CPS_OP_IRQ, CPS_OP_NMI} |=> ctx ==
		(($past(cmd.op) == CPS_OP_IRQ) ? CPS_CTX_IRQ : CPS_CTX_NMI)) else $error("ctx not switched");
	a_arith_flags: assert property (
		take && cmd.op == CPS_OP_ARITH && !ds_req.wr |=> accumulator == $past(cmd.result)
		&& carry_active == $past(cmd.carry_out) && zero_active == ($past(cmd.result) == 8'h00))
		else $error("arith result or flags wrong");
	a_ds_map: assert property (
		ds_req.rd |=> ds_hit == $past(mapped) && ($past(mapped) || ds_rdata == 8'h00))
		else $error("data space decode wrong");
	a_acc_write: assert property (
		ds_req.wr && ds_req.addr == 8'hff |=> accumulator == $past(ds_req.wdata))
		else $error("accumulator write lost");
endmodule // cps_core_regs_sva

bind cps_core_regs cps_core_regs_sva u_cps_core_regs_sva (
	.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
	.ds_req(ds_req), .ds_rdata(ds_rdata), .ds_hit(ds_hit), .pc(pc), .accumulator(accumulator),
	.carry_active(carry_active), .zero_active(zero_active), .ctx(ctx),
	.stack_depth(stack_depth), .mc_tick(mc_tick), .busy(busy));

// ===== test/cps_core_regs_tb_top.sv
// testbench: drives the core register block and checks it against a reference model
module cps_core_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cps_pkg::*;

	localparam logic [7:0] ADDRS [6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84};
	logic               ref_clk;
	logic               rstn;
	logic               cmd_valid;
	logic               cmd_ready;
	cps_cmd_s           cmd;
	cps_ds_req_s        ds_req;
	logic [7:0]         ds_rdata;
	logic               ds_hit;
	logic [PC_W-1:0]    pc;
	logic [7:0]         accumulator;
	logic               carry_active;
	logic               zero_active;
	cps_ctx_e           ctx;
	logic [DEPTH_W-1:0] stack_depth;
	logic               mc_tick;
	logic               busy;
	logic               rd_d;
	logic               snap;
	logic               sn_d;
	int                 err_total;
	int                 total_checks;
	logic [8:0]         eq_ds[$];
	logic [26:0]        eq_st[$];
	logic [PC_W-1:0]    m_pc;
	logic [7:0]         m_acc;
	logic [7:0]         m_ds[4];
	logic [2:0]         m_c;
	logic [2:0]         m_z;
	cps_ctx_e           m_ctx;
	cps_ctx_e           m_hist[$];
	logic [PC_W-1:0]    m_stk[$];

	cps_core_regs u_cps_core_regs (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .ds_req(ds_req), .ds_rdata(ds_rdata), .ds_hit(ds_hit),
		.pc(pc), .accumulator(accumulator), .carry_active(carry_active),
		.zero_active(zero_active), .ctx(ctx), .stack_depth(stack_depth), .mc_tick(mc_tick),
		.busy(busy));
	cps_prog_src u_cps_prog_src (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
		.cmd_valid(cmd_valid), .cmd(cmd));

	// 10 MHz clock
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	// ---------------------------------------------------------------
	// result watcher
	// ---------------------------------------------------------------
	task automatic check(string what, logic [26:0] exp, logic [26:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// read data lands one cycle after the request, so remember which cycles asked
	always @(posedge ref_clk) begin
		rd_d <= ds_req.rd;
		sn_d <= snap;
	end
	always @(negedge ref_clk) begin
		if (rd_d === 1'b1 && eq_ds.size() > 0)
			check("ds_read", 27'(eq_ds.pop_front()), 27'({ds_hit, ds_rdata}));
		if (sn_d === 1'b1 && eq_st.size() > 0)
			check("state", eq_st.pop_front(),
				{pc, ctx, stack_depth, carry_active, zero_active, accumulator});
	end

	// ---------------------------------------------------------------
	// drivers and model
	// ---------------------------------------------------------------
	function automatic logic [8:0] exp_rd(logic [7:0] a);
		if (a == 8'hff)
			return {1'b1, m_acc};
		if (a[7:2] == 6'h20)
			return {1'b1, m_ds[a[1:0]]};
		return 9'h000;
	endfunction

	task automatic ds(logic rd, logic wr, logic [7:0] a, logic [7:0] d);
		@(negedge ref_clk);
		ds_req = '{rd: rd, wr: wr, addr: a, wdata: d};
		if (rd)
			eq_ds.push_back(exp_rd(a));
		if (wr && a == 8'hff)
			m_acc = d;
		if (wr && a[7:2] == 6'h20)
			m_ds[a[1:0]] = d;
	endtask

	task automatic snapshot();
		@(negedge ref_clk);
		snap = 1'b1;
		eq_st.push_back({m_pc, m_ctx, 3'(m_stk.size()), m_c[m_ctx], m_z[m_ctx], m_acc});
		@(negedge ref_clk);
		snap = 1'b0;
	endtask

	task automatic run(cps_op_e op, logic [11:0] tg, logic [7:0] v, logic cb);
		cps_cmd_s c;
		int k;
		logic ok;
		// k == 3 offers an illegal length, which must behave as two cycles
		k = $urandom_range(3);
		c = '{op: op, cycles: (k == 0) ? 3'h2 : (k == 1) ? 3'h4 : (k == 2) ? 3'h5 : 3'h7,
			target: tg,
			offset: v, result: v, carry_out: cb, bit_val: cb};
		k = int'(m_ctx);
		if (op inside {CPS_OP_CALL, CPS_OP_IRQ, CPS_OP_NMI}) begin
			m_stk.push_front(m_pc);
			if (m_stk.size() > 6)
				void'(m_stk.pop_back());
		end
		if (op inside {CPS_OP_IRQ, CPS_OP_NMI}) begin
			m_hist.push_front(m_ctx);
			if (m_hist.size() > 2)
				void'(m_hist.pop_back());
			m_ctx = (op == CPS_OP_IRQ) ? CPS_CTX_IRQ : CPS_CTX_NMI;
		end
		if (op inside {CPS_OP_RET, CPS_OP_RETURN_FROM_INTERRUPT} && m_stk.size() > 0)
			m_pc = m_stk.pop_front();
		if (op == CPS_OP_RETURN_FROM_INTERRUPT)
			m_ctx = (m_hist.size() > 0) ? m_hist.pop_front() : CPS_CTX_MAIN;
		case (op)
			CPS_OP_FETCH: m_pc = m_pc + 12'h001;
			CPS_OP_JUMP, CPS_OP_CALL, CPS_OP_IRQ, CPS_OP_NMI: m_pc = tg;
			CPS_OP_BRANCH: m_pc = m_pc + {{4{v[7]}}, v};
			CPS_OP_ARITH: {m_c[k], m_z[k], m_acc} = {cb, v == 8'h00, v};
			CPS_OP_LOGIC: {m_z[k], m_acc} = {v == 8'h00, v};
			CPS_OP_BITTEST: m_c[k] = cb;
			CPS_OP_ROTL: {m_c[k], m_acc} = {m_acc, m_c[k]};
			default: ;
		endcase
		u_cps_prog_src.issue(c, ok);
		total_checks++;
		if (!ok) begin
			err_total++;
			$display("[FAIL] cmd_ready expected 1 seen 0");
		end
		snapshot();
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// hang guard, well beyond the expected few thousand cycles
	initial begin
		#2_000_000;
		err_total++;
		$display("[FAIL] watchdog expected done seen running");
		tally_and_finish();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'hee40_20e4));
		{rstn, snap, err_total, total_checks} = '0;
		ds_req = '0;
		{m_acc, m_c, m_z} = '0;
		m_ds = '{default: 8'h00};
		m_pc = RESET_VEC;
		m_ctx = CPS_CTX_NMI;
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		rstn = 1'b1;
		repeat (3) @(negedge ref_clk);
		snapshot();
		// data-space map: reset values, random writes, read back, unmapped place included
		foreach (ADDRS[i]) ds(1'b1, 1'b0, ADDRS[i], 8'h00);
		foreach (ADDRS[i]) ds(1'b0, 1'b1, ADDRS[i], 8'($urandom));
		foreach (ADDRS[i]) ds(1'b1, 1'b0, ADDRS[i], 8'h00);
		ds(1'b1, 1'b1, 8'hff, 8'h5a);
		ds(1'b1, 1'b0, 8'hff, 8'h00);
		ds(1'b0, 1'b0, 8'h00, 8'h00);
		// flag work in each context, flags kept across switches
		run(CPS_OP_ARITH, '0, 8'h00, 1'b1);
		run(CPS_OP_ROTL, '0, 8'h00, 1'b0);
		run(CPS_OP_BITTEST, '0, 8'h00, 1'b1);
		run(CPS_OP_LOGIC, '0, 8'h3c, 1'b0);
		run(CPS_OP_RETURN_FROM_INTERRUPT, '0, 8'h00, 1'b0);
		run(CPS_OP_ARITH, '0, 8'h81, 1'b1);
		run(CPS_OP_IRQ, 12'hff0, 8'h00, 1'b0);
		run(CPS_OP_ARITH, '0, 8'h00, 1'b0);
		run(CPS_OP_NMI, 12'hffc, 8'h00, 1'b0);
		run(CPS_OP_RETURN_FROM_INTERRUPT, '0, 8'h00, 1'b0);
		run(CPS_OP_RETURN_FROM_INTERRUPT, '0, 8'h00, 1'b0);
		// pc wrap at both ends of the 4096-byte space
		run(CPS_OP_JUMP, 12'hfff, 8'h00, 1'b0);
		run(CPS_OP_FETCH, '0, 8'h00, 1'b0);
		run(CPS_OP_BRANCH, '0, 8'h80, 1'b0);
		run(CPS_OP_BRANCH, '0, 8'h7f, 1'b0);
		// seven nested calls overflow the six levels, eight returns run past empty
		repeat (7) run(CPS_OP_CALL, 12'($urandom), 8'h00, 1'b0);
		repeat (8) run(CPS_OP_RET, '0, 8'h00, 1'b0);
		// random mix of every operation
		repeat (24) run(cps_op_e'($urandom_range(11)), 12'($urandom), 8'($urandom), 1'($urandom));
		tally_and_finish();
	end
endmodule // cps_core_regs_tb_top

// ===== test/cps_prog_src.sv
// partner: program-memory side that offers instruction commands to the core
module cps_prog_src (
	input  wire logic        ref_clk,
	input  wire logic        cmd_ready,
	output logic             cmd_valid,
	output cps_pkg::cps_cmd_s cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	import cps_pkg::*;

	// idle until the first offer
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// offer after a random stall, hold until taken; idle lines show junk, not the old value
	task automatic issue(input cps_cmd_s c, output logic ok);
		int n;
		repeat ($urandom_range(3)) @(negedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd = c;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		ok = (n < 200);
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd = ~c;
	endtask
endmodule // cps_prog_src
